// *** hdl/bbp_duty_meter.sv ***
// Duty cycle meter for the PWM input, 11-bit result per window
`include "bbp_regs.svh"
module bbp_duty_meter
  import bbp_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        pwm_i,
  output logic [10:0]      duty_code_o
);

  logic        pwm_s1;
  logic        pwm_s2;
  logic        pwm_s3;
  logic        pwm_lvl;
  logic [3:0]  smp_cnt;
  logic [10:0] win_cnt;
  logic [10:0] high_cnt;
  logic        next_pwm_lvl;
  logic [3:0]  next_smp_cnt;
  logic [10:0] next_win_cnt;
  logic [10:0] next_high_cnt;
  logic [10:0] next_duty_code;
  logic        smp_en;

  // ==========================================================
  // Window of 2047 samples, the high count is the duty code
  always_comb begin
    next_pwm_lvl   = (pwm_s2 == pwm_s3) ? pwm_s3 : pwm_lvl;
    smp_en         = (smp_cnt == 4'(`BBP_SAMPLE_CYC - 1));
    next_smp_cnt   = smp_en ? 4'h0 : smp_cnt + 4'h1;
    next_win_cnt   = win_cnt;
    next_high_cnt  = high_cnt;
    next_duty_code = duty_code_o;
    if (smp_en) begin
      if (win_cnt == `BBP_CODE_FULL - 11'h001) begin
        next_duty_code = high_cnt + {10'h000, pwm_lvl};
        next_win_cnt   = `BBP_RST_CODE;
        next_high_cnt  = `BBP_RST_CODE;
      end else begin
        next_win_cnt  = win_cnt + 11'h001;
        next_high_cnt = high_cnt + {10'h000, pwm_lvl};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    pwm_s1 <= pwm_i;
    pwm_s2 <= pwm_s1;
    pwm_s3 <= pwm_s2;
    if (sys_rst_i) begin
      pwm_lvl     <= 1'b0;
      smp_cnt     <= 4'h0;
      win_cnt     <= `BBP_RST_CODE;
      high_cnt    <= `BBP_RST_CODE;
      duty_code_o <= `BBP_RST_CODE;
    end else begin
      pwm_lvl     <= next_pwm_lvl;
      smp_cnt     <= next_smp_cnt;
      win_cnt     <= next_win_cnt;
      high_cnt    <= next_high_cnt;
      duty_code_o <= next_duty_code;
    end
  end

endmodule : bbp_duty_meter

// *** hdl/bbp_path.sv ***
// Brightness path: source select, ramper, adjust override, boost freq
`include "bbp_regs.svh"
// What this block does
// - Mode 01 takes brightness from PWM duty only, host code ignored
// - PWM input sampled, duty measured as 11-bit code, fed to ramper in modes 01 and 10
// - Mode 10 multiplies host code by duty, product feeds the ramper
// - Mode 11 ramps host code only, duty multiplies ramper output
// - Boost control bit 5 selects 500 kHz or 1 MHz nominal
// - Boost control bit 6 shifts the nominal frequency down 12 percent
// - 250 kHz only in automatic mode, duty limited to 50 percent
// - Auto mode compares thresholds with the brightness MSB register
// - Below low gives 250 kHz, at or above high 1 MHz, else 500
// - Auto mode whenever a threshold is nonzero, else fixed frequency
// - Reduced target comes from register 0x17, adjusts MSBs only
// - Adjust override only lowers current, never raises it
// - Under adjust the mapper code is reduced target MSBs and three zeros
// - Reduced target reached well under 50 us, without ramping
// - On adjust release the prior brightness target returns
// - Mode 00 acts on a new host code only when MSBs are written
// - Eight ramp rates, each a time per code step
// - Control bit 0 selects adjust input polarity, high by default
module bbp_path
  import bbp_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [7:0]       reg_rdata_o,
  input  wire logic        pwm_i,
  input  wire logic        backlight_reduce_input_i,
  output logic [10:0]      led_current_code_o,
  output bbp_boost_type    boost_o
);

  // ==========================================================
  // Functions
  function automatic logic [10:0] mul11(input logic [10:0] a,
                                        input logic [10:0] d);
    logic [21:0] p;
    p = a * d;
    if (d == `BBP_CODE_FULL) begin
      return a;
    end
    return p[21:11];
  endfunction : mul11

  function automatic logic [7:0] step_us(input logic [2:0] rate);
    return `BBP_STEP_US_BASE << rate;
  endfunction : step_us

  // ==========================================================
  // Registers
  bbp_brt_ctrl_type brt_ctrl;
  logic [7:0]       boost_ctrl;
  logic [7:0]       af_high;
  logic [7:0]       af_low;
  logic [7:0]       reduce_tgt;
  logic [2:0]       brt_low;
  logic [7:0]       brt_high;
  logic [10:0]      host_code;
  bbp_brt_ctrl_type next_brt_ctrl;
  logic [7:0]       next_boost_ctrl;
  logic [7:0]       next_af_high;
  logic [7:0]       next_af_low;
  logic [7:0]       next_reduce_tgt;
  logic [2:0]       next_brt_low;
  logic [7:0]       next_brt_high;
  logic [10:0]      next_host_code;
  logic [7:0]       next_rdata;
  logic [7:0]       status;

  // ==========================================================
  // Brightness state
  logic [10:0]      duty_code;
  logic [10:0]      target;
  logic [10:0]      ramp_code;
  logic [7:0]       step_cnt;
  logic [5:0]       tick_cnt;
  logic             tick;
  logic             ramp_busy;
  logic [10:0]      base_code;
  logic [10:0]      reduced_code;
  logic [10:0]      next_ramp_code;
  logic [7:0]       next_step_cnt;
  logic [5:0]       next_tick_cnt;
  logic [10:0]      next_led_code;

  // ==========================================================
  // Adjust input synchroniser
  logic             adj_s1;
  logic             adj_s2;
  logic             adj_s3;
  logic             adj_lvl;
  logic             next_adj_lvl;
  logic             adj_on;

  // ==========================================================
  // Boost frequency
  logic             auto_mode;
  bbp_boost_type    next_boost;

  // ==========================================================
  // Register writes and reads
  always_comb begin
    next_brt_ctrl   = brt_ctrl;
    next_boost_ctrl = boost_ctrl;
    next_af_high    = af_high;
    next_af_low     = af_low;
    next_reduce_tgt = reduce_tgt;
    next_brt_low    = brt_low;
    next_brt_high   = brt_high;
    next_host_code  = host_code;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        `BBP_ADDR_BRT_CTRL: begin
          next_brt_ctrl.mode =
            bbp_mode_type'(reg_wdata_i[`BBP_MODE_MSB:`BBP_MODE_LSB]);
          next_brt_ctrl.rate = reg_wdata_i[`BBP_RATE_MSB:`BBP_RATE_LSB];
          next_brt_ctrl.pol  = reg_wdata_i[`BBP_POL_BIT];
        end
        `BBP_ADDR_BOOST:    next_boost_ctrl = reg_wdata_i;
        `BBP_ADDR_AF_HIGH:  next_af_high    = reg_wdata_i;
        `BBP_ADDR_AF_LOW:   next_af_low     = reg_wdata_i;
        `BBP_ADDR_REDUCE:   next_reduce_tgt = reg_wdata_i;
        `BBP_ADDR_BRT_LOW:  next_brt_low    = reg_wdata_i[2:0];
        `BBP_ADDR_BRT_HIGH: begin
          next_brt_high  = reg_wdata_i;
          next_host_code = {reg_wdata_i, brt_low};
        end
        default: ;
      endcase
    end
    status = {4'h0, adj_on, ramp_busy, boost_o.freq};
    next_rdata = reg_rdata_o;
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `BBP_ADDR_BRT_CTRL: next_rdata = {1'b0, brt_ctrl.mode, 1'b0,
                                          brt_ctrl.rate, brt_ctrl.pol};
        `BBP_ADDR_BOOST:    next_rdata = boost_ctrl;
        `BBP_ADDR_AF_HIGH:  next_rdata = af_high;
        `BBP_ADDR_AF_LOW:   next_rdata = af_low;
        `BBP_ADDR_REDUCE:   next_rdata = reduce_tgt;
        `BBP_ADDR_BRT_LOW:  next_rdata = {5'h00, brt_low};
        `BBP_ADDR_BRT_HIGH: next_rdata = brt_high;
        `BBP_ADDR_STATUS:   next_rdata = status;
        default:            next_rdata = `BBP_RST_BYTE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      brt_ctrl    <= '{BBP_MODE_HOST, 3'h0, 1'b0};
      boost_ctrl  <= `BBP_RST_BYTE;
      af_high     <= `BBP_RST_BYTE;
      af_low      <= `BBP_RST_BYTE;
      reduce_tgt  <= `BBP_RST_BYTE;
      brt_low     <= 3'h0;
      brt_high    <= `BBP_RST_BYTE;
      host_code   <= `BBP_RST_CODE;
      reg_rdata_o <= `BBP_RST_BYTE;
    end else begin
      brt_ctrl    <= next_brt_ctrl;
      boost_ctrl  <= next_boost_ctrl;
      af_high     <= next_af_high;
      af_low      <= next_af_low;
      reduce_tgt  <= next_reduce_tgt;
      brt_low     <= next_brt_low;
      brt_high    <= next_brt_high;
      host_code   <= next_host_code;
      reg_rdata_o <= next_rdata;
    end
  end

  // ==========================================================
  // Duty measurement
  bbp_duty_meter u_duty (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .pwm_i       (pwm_i),
    .duty_code_o (duty_code)
  );

  // ==========================================================
  // Source select and ramper
  always_comb begin
    unique case (brt_ctrl.mode)
      BBP_MODE_HOST:     target = host_code;
      BBP_MODE_PWM:      target = duty_code;
      BBP_MODE_MUL_RAMP: target = mul11(host_code, duty_code);
      BBP_MODE_RAMP_MUL: target = host_code;
    endcase
    tick          = (tick_cnt == 6'(`BBP_TICK_CYC - 1));
    next_tick_cnt = tick ? 6'h00 : tick_cnt + 6'h01;
    ramp_busy     = (ramp_code != target);
    next_ramp_code = ramp_code;
    next_step_cnt  = step_cnt;
    if (!ramp_busy) begin
      next_step_cnt = 8'h00;
    end else if (tick) begin
      if (step_cnt + 8'h01 >= step_us(brt_ctrl.rate)) begin
        next_step_cnt  = 8'h00;
        next_ramp_code = (target > ramp_code) ? ramp_code + 11'h001
                                              : ramp_code - 11'h001;
      end else begin
        next_step_cnt = step_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tick_cnt  <= 6'h00;
      step_cnt  <= 8'h00;
      ramp_code <= `BBP_RST_CODE;
    end else begin
      tick_cnt  <= next_tick_cnt;
      step_cnt  <= next_step_cnt;
      ramp_code <= next_ramp_code;
    end
  end

  // ==========================================================
  // Adjust override at the mapper input
  always_comb begin
    next_adj_lvl = (adj_s2 == adj_s3) ? adj_s3 : adj_lvl;
    adj_on       = adj_lvl ^ brt_ctrl.pol;
    base_code    = (brt_ctrl.mode == BBP_MODE_RAMP_MUL)
                 ? mul11(ramp_code, duty_code) : ramp_code;
    reduced_code = {reduce_tgt, 3'b000};
    next_led_code = base_code;
    if (adj_on && (reduced_code < base_code)) begin
      next_led_code = reduced_code;
    end
  end

  always_ff @(posedge clk_i) begin
    adj_s1 <= backlight_reduce_input_i;
    adj_s2 <= adj_s1;
    adj_s3 <= adj_s2;
    if (sys_rst_i) begin
      adj_lvl            <= 1'b0;
      led_current_code_o <= `BBP_RST_CODE;
    end else begin
      adj_lvl            <= next_adj_lvl;
      led_current_code_o <= next_led_code;
    end
  end

  // ==========================================================
  // Boost switching frequency
  always_comb begin
    auto_mode             = (af_high != 8'h00) || (af_low != 8'h00);
    next_boost.shift      = boost_ctrl[`BBP_SHIFT_BIT];
    next_boost.ind_range  = boost_ctrl[`BBP_IND_BIT];
    next_boost.freq       = boost_ctrl[`BBP_FSEL_BIT] ? BBP_F1M
                                                      : BBP_F500;
    if (auto_mode) begin
      if (brt_high < af_low) begin
        next_boost.freq = BBP_F250;
      end else if (brt_high >= af_high) begin
        next_boost.freq = BBP_F1M;
      end else begin
        next_boost.freq = BBP_F500;
      end
    end
    next_boost.half_limit = (next_boost.freq == BBP_F250);
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      boost_o <= '{BBP_F500, 1'b0, 1'b0, 1'b0};
    end else begin
      boost_o <= next_boost;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  sequence seq_adj_cut;
    adj_on && (reduced_code < base_code);
  endsequence

  sequence seq_lsb_write;
    reg_wr_i && (reg_addr_i == `BBP_ADDR_BRT_LOW);
  endsequence

  AST_PWM_ONLY: assert property (
    (brt_ctrl.mode == BBP_MODE_PWM) && $stable(duty_code)
    && !$stable(host_code) |-> $stable(target))
    else $error("host code moved the target in PWM mode");

  AST_MUL_RAMP: assert property (
    brt_ctrl.mode == BBP_MODE_MUL_RAMP |->
      target == mul11(host_code, duty_code))
    else $error("mode 10 target is not the product");

  AST_RAMP_MUL: assert property (
    (brt_ctrl.mode == BBP_MODE_RAMP_MUL) && !adj_on && !sys_rst_i
    ##1 $stable(brt_ctrl.mode) |->
      led_current_code_o == mul11($past(ramp_code), $past(duty_code)))
    else $error("mode 11 output is not ramp times duty");

  AST_FIXED_FREQ: assert property (
    !auto_mode |=>
      boost_o.freq == ($past(boost_ctrl[`BBP_FSEL_BIT]) ? BBP_F1M
                                                        : BBP_F500))
    else $error("fixed frequency does not follow select bit");

  AST_HALF_LIMIT: assert property (
    (boost_o.half_limit == (boost_o.freq == BBP_F250)) &&
    ((boost_o.freq != BBP_F250) || $past(auto_mode)))
    else $error("250 kHz or its duty limit outside auto mode");

  AST_AUTO_LOW: assert property (
    auto_mode && (brt_high < af_low) |=> boost_o.freq == BBP_F250)
    else $error("auto mode missed 250 kHz below low threshold");

  AST_ADJ_CUT: assert property (
    seq_adj_cut |=> led_current_code_o == {$past(reduce_tgt), 3'b000})
    else $error("adjust did not cut to reduced code in one cycle");

  AST_ADJ_ONLY_DOWN: assert property (
    ##1 led_current_code_o <= $past(base_code))
    else $error("adjust raised the current");

  AST_LSB_HOLD: assert property (
    seq_lsb_write |=> $stable(host_code))
    else $error("LSB write changed the active host code");

  AST_ONE_STEP: assert property (
    !$stable(ramp_code) |-> $past(tick) &&
      ((ramp_code == $past(ramp_code) + 11'h001) ||
       (ramp_code == $past(ramp_code) - 11'h001)))
    else $error("ramper moved other than one LSB on a tick");

endmodule : bbp_path

// *** include/bbp_pkg.sv ***
// Types shared by the brightness path modules
package bbp_pkg;

  typedef enum logic [1:0] {
    BBP_MODE_HOST     = 2'b00,
    BBP_MODE_PWM      = 2'b01,
    BBP_MODE_MUL_RAMP = 2'b10,
    BBP_MODE_RAMP_MUL = 2'b11
  } bbp_mode_type;

  typedef enum logic [1:0] {
    BBP_F250 = 2'b00,
    BBP_F500 = 2'b01,
    BBP_F1M  = 2'b10
  } bbp_freq_type;

  typedef struct packed {
    bbp_mode_type mode;
    logic [2:0]   rate;
    logic         pol;
  } bbp_brt_ctrl_type;

  typedef struct packed {
    bbp_freq_type freq;
    logic         shift;
    logic         half_limit;
    logic         ind_range;
  } bbp_boost_type;

endpackage : bbp_pkg

// *** include/bbp_regs.svh ***
// Register offsets, field positions, reset values and timing counts
`ifndef BBP_REGS_SVH
`define BBP_REGS_SVH

// ==========================================================
// Register offsets
`define BBP_ADDR_BRT_CTRL   8'h11
`define BBP_ADDR_BOOST      8'h13
`define BBP_ADDR_AF_HIGH    8'h15
`define BBP_ADDR_AF_LOW     8'h16
`define BBP_ADDR_REDUCE     8'h17
`define BBP_ADDR_BRT_LOW    8'h18
`define BBP_ADDR_BRT_HIGH   8'h19
`define BBP_ADDR_STATUS     8'h1C

// ==========================================================
// Field positions
`define BBP_POL_BIT         0
`define BBP_RATE_LSB        1
`define BBP_RATE_MSB        3
`define BBP_MODE_LSB        5
`define BBP_MODE_MSB        6
`define BBP_IND_BIT         4
`define BBP_FSEL_BIT        5
`define BBP_SHIFT_BIT       6

// ==========================================================
// Reset values and full-scale code
`define BBP_RST_BYTE        8'h00
`define BBP_RST_CODE        11'h000
`define BBP_CODE_FULL       11'h7FF

// ==========================================================
// Timing
`define BBP_CLK_MHZ         40
`define BBP_TICK_NS         1000
`define BBP_TICK_CYC        ((`BBP_TICK_NS * `BBP_CLK_MHZ) / 1000)
`define BBP_SAMPLE_NS       250
`define BBP_SAMPLE_CYC      ((`BBP_SAMPLE_NS * `BBP_CLK_MHZ) / 1000)
`define BBP_STEP_US_BASE    8'h01
`define BBP_ADJ_MAX_NS      50000
`define BBP_ADJ_MAX_CYC     ((`BBP_ADJ_MAX_NS * `BBP_CLK_MHZ) / 1000)

`endif

// *** test/bbp_host_model.sv ***
// Host processor model: register bus, PWM and adjust pins
`include "bbp_regs.svh"
module bbp_host_model
  import bbp_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output logic [7:0]      addr_o,
  output logic [7:0]      wdata_o,
  output logic            wr_o,
  output logic            rd_o,
  output logic            pwm_o,
  output logic            adj_o
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    addr_o  = 8'h00;
    wdata_o = 8'h00;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    pwm_o   = 1'b0;
    adj_o   = 1'b0;
  end

  // ==========================================================
  // Bus cycles: one strobed edge, then the idle bus is scrambled
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o  = a;
    wdata_o = d;
    wr_o    = 1'b1;
    @(posedge clk_i);
    #1;
    wr_o    = 1'b0;
    addr_o  = ~a;
    wdata_o = ~d;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    rd_o   = 1'b1;
    @(posedge clk_i);
    #1;
    rd_o   = 1'b0;
    addr_o = ~a;
    @(posedge clk_i);
    #1;
    d = rdata_i;
  endtask : rd

  // Low bits first, the high byte commits the code
  task automatic code(input logic [10:0] c);
    wr(`BBP_ADDR_BRT_LOW, {5'h00, c[2:0]});
    wr(`BBP_ADDR_BRT_HIGH, c[10:3]);
  endtask : code

  task automatic pins(input logic p, input logic a);
    @(posedge clk_i);
    #1;
    pwm_o = p;
    adj_o = a;
  endtask : pins
endmodule : bbp_host_model

// *** test/bbp_path_tb.sv ***
// Self-checking bench for the brightness path
`include "bbp_regs.svh"
module bbp_path_tb
  import bbp_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic          clk, rst, wr, rd, pwm, adj;
  logic [7:0]    addr, wdata, rdata, rv;
  logic [10:0]   led;
  bbp_boost_type boost;
  int            failures, cmp_count, cyc;
  logic [7:0]    bst [8] = '{8'h00, 8'h20, 8'h60, 8'h50,
                             8'h20, 8'h00, 8'h00, 8'h40};
  logic [7:0]    thi [8] = '{8'h00, 8'h00, 8'h00, 8'h00,
                             8'h00, 8'h10, 8'h04, 8'h05};
  logic [7:0]    tlo [8] = '{8'h00, 8'h00, 8'h00, 8'h00,
                             8'h05, 8'h04, 8'h01, 8'h00};
  bbp_freq_type  efq [8] = '{BBP_F500, BBP_F1M, BBP_F1M, BBP_F500,
                             BBP_F250, BBP_F500, BBP_F1M, BBP_F500};
  logic [2:0]    efl [8] = '{3'h0, 3'h0, 3'h4, 3'h5,
                             3'h2, 3'h0, 3'h0, 3'h4};

  bbp_path bbp_path_i (
    .clk_i                    (clk),
    .sys_rst_i                (rst),
    .reg_addr_i               (addr),
    .reg_wdata_i              (wdata),
    .reg_wr_i                 (wr),
    .reg_rd_i                 (rd),
    .reg_rdata_o              (rdata),
    .pwm_i                    (pwm),
    .backlight_reduce_input_i (adj),
    .led_current_code_o       (led),
    .boost_o                  (boost)
  );

  bbp_host_model bbp_host_model_i (
    .clk_i   (clk),
    .rdata_i (rdata),
    .addr_o  (addr),
    .wdata_o (wdata),
    .wr_o    (wr),
    .rd_o    (rd),
    .pwm_o   (pwm),
    .adj_o   (adj)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      failures++;
      results();
    end
  end

  // ==========================================================
  // Checks and helpers
  task automatic note(input logic ok, input string m);
    cmp_count++;
    if (!ok) begin
      failures++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : note

  task automatic chk11(input logic [10:0] g, input logic [10:0] e,
                       input string m);
    note(g === e, m);
  endtask : chk11

  task automatic chk8(input logic [7:0] g, input logic [7:0] e,
                      input string m);
    note(g === e, m);
  endtask : chk8

  task automatic chkb(input bbp_boost_type g, input bbp_boost_type e,
                      input string m);
    note(g === e, m);
  endtask : chkb

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : idle

  task automatic w(input logic [7:0] a, input logic [7:0] d);
    bbp_host_model_i.wr(a, d);
  endtask : w

  task automatic r(input logic [7:0] a);
    bbp_host_model_i.rd(a, rv);
  endtask : r

  task automatic wait_code(input logic [10:0] e, input int lim);
    int n;
    n = 0;
    while (led !== e && n < lim) begin
      idle(1);
      n++;
    end
    chk11(led, e, "code not reached in time");
  endtask : wait_code

  // Follows a ramp, checking step size and the steady step spacing
  task automatic ramp(input logic [10:0] to, input int rt);
    logic [10:0] prev;
    int          gap, steps, n;
    prev  = led;
    gap   = 0;
    steps = 0;
    n     = 0;
    while (prev !== to && n < 30000) begin
      idle(1);
      n++;
      gap++;
      if (led !== prev) begin
        chk11(led, (to > prev) ? prev + 11'h001 : prev - 11'h001,
              "ramp step");
        if (steps > 0) chk11(11'(gap), 11'(40 << rt), "step time");
        prev  = led;
        gap   = 0;
        steps++;
      end
    end
    idle(100);
    chk11(led, to, "ramp end");
  endtask : ramp

  task automatic results();
    $display("Comparisons %0d, failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  // ==========================================================
  // Test sequence
  initial begin
    rst = 1'b1;
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    idle(4);
    chk11(led, 11'h000, "led reset");
    chkb(boost, '{BBP_F500, 1'b0, 1'b0, 1'b0}, "boost reset");
    r(`BBP_ADDR_REDUCE);
    chk8(rv, 8'h00, "reduce reset");
    w(8'h30, 8'hA5);
    r(8'h30);
    chk8(rv, 8'h00, "unmapped read");
    for (int k = 0; k < 4; k++) begin
      w(`BBP_ADDR_BRT_CTRL, 8'(k << 1));
      bbp_host_model_i.code(11'(3 * (k + 1)));
      ramp(11'(3 * (k + 1)), k);
    end
    w(`BBP_ADDR_BRT_CTRL, 8'h00);
    w(`BBP_ADDR_BRT_LOW, 8'h07);
    idle(200);
    chk11(led, 11'h00C, "low byte alone");
    w(`BBP_ADDR_BRT_HIGH, 8'h04);
    ramp(11'h027, 0);
    w(`BBP_ADDR_REDUCE, 8'h02);
    bbp_host_model_i.pins(1'b0, 1'b1);
    wait_code(11'h010, `BBP_ADJ_MAX_CYC);
    bbp_host_model_i.pins(1'b0, 1'b0);
    wait_code(11'h027, 10);
    w(`BBP_ADDR_REDUCE, 8'h10);
    bbp_host_model_i.pins(1'b0, 1'b1);
    idle(50);
    chk11(led, 11'h027, "adjust raised");
    w(`BBP_ADDR_REDUCE, 8'h03);
    w(`BBP_ADDR_BRT_CTRL, 8'h01);
    idle(20);
    chk11(led, 11'h027, "inverted idle");
    r(`BBP_ADDR_BRT_CTRL);
    chk8(rv, 8'h01, "control readback");
    bbp_host_model_i.pins(1'b0, 1'b0);
    wait_code(11'h018, `BBP_ADJ_MAX_CYC);
    bbp_host_model_i.pins(1'b0, 1'b1);
    wait_code(11'h027, 10);
    bbp_host_model_i.pins(1'b0, 1'b0);
    w(`BBP_ADDR_BRT_CTRL, 8'h00);
    for (int k = 0; k < 8; k++) begin
      w(`BBP_ADDR_BOOST, bst[k]);
      w(`BBP_ADDR_AF_HIGH, thi[k]);
      w(`BBP_ADDR_AF_LOW, tlo[k]);
      idle(3);
      chkb(boost, bbp_boost_type'({efq[k], efl[k]}),
           "boost");
      r(`BBP_ADDR_AF_LOW);
      chk8(rv, tlo[k], "threshold readback");
    end
    r(`BBP_ADDR_STATUS);
    chk8(rv, 8'h01, "status");
    r(`BBP_ADDR_BRT_HIGH);
    chk8(rv, 8'h04, "brightness readback");
    w(`BBP_ADDR_BRT_CTRL, 8'h60);
    wait_code(11'h000, 6);
    w(`BBP_ADDR_BRT_CTRL, 8'h40);
    idle(5);
    ramp(11'h000, 0);
    w(`BBP_ADDR_BRT_CTRL, 8'h20);
    bbp_host_model_i.code(11'h037);
    idle(300);
    chk11(led, 11'h000, "host code used");
    w(`BBP_ADDR_BRT_CTRL, 8'h60);
    idle(2500);
    chk11(led, 11'h000, "zero duty product");
    bbp_host_model_i.pins(1'b1, 1'b0);
    wait_code(11'h037, 42000);
    w(`BBP_ADDR_BRT_CTRL, 8'h40);
    idle(100);
    chk11(led, 11'h037, "full duty product");
    results();
  end
endmodule : bbp_path_tb
